// ===== design/scccb_pkg.sv
// package: constants and carriers for the sensor coil bank
package scccb_pkg;
  // coil addresses
  localparam logic [15:0] COIL_TERM = 16'h0000;
  localparam logic [15:0] COIL_PORT = 16'h0001;
  localparam logic [15:0] COIL_APPLY = 16'h0002;
  localparam logic [15:0] COIL_FLUSH = 16'h0005;
  localparam logic [15:0] COIL_BOOT = 16'h0007;
  localparam logic [15:0] COIL_LAST = 16'h000F; // 8..15 reserved, read zero
  // register addresses
  localparam logic [15:0] REG_FAULT = 16'h02BC; // fault/status word, 700
  localparam logic [15:0] REG_FAULT_RSV = 16'h02BD; // reserved word, 701
  localparam logic [15:0] REG_MSB_MIRROR = 16'h00C8; // 200, msb first
  localparam logic [15:0] REG_LSB_MIRROR = 16'h0064; // 100, lsb first
  // function codes
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_WRITE_COILS = 8'h0F;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [15:0] SFC_RET_DIAG = 16'h0002;
  localparam logic [15:0] SFC_CLR_DIAG = 16'h000A;
  // exception codes
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  // fault bits cleared by port reconfigure
  localparam logic [15:0] FAULT_SERIAL_MASK = 16'h0003;
  // baud selection
  localparam logic [31:0] BAUD_DEFAULT = 32'h0000_4B00; // 19200
  localparam int BAUD_TOL_PCT = 2;
  localparam int BAUD_N = 10;
  // timing
  localparam longint CLK_HZ = 125_000_000;
  localparam longint ACT_TIME_MS = 1000; // port/apply/flush, ~1 s
  localparam longint BOOT_TIME_MS = 4500; // reboot, 4-5 s
  localparam longint ACT_CYC_L = (CLK_HZ * ACT_TIME_MS) / 1000;
  localparam longint BOOT_CYC_L = (CLK_HZ * BOOT_TIME_MS) / 1000;
  localparam int CNT_W = 30;

  // request from the frame decoder
  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [15:0] addr; // coil/register address or sub-function
    logic [15:0] qty; // quantity, or coil write value
  } scccb_req_t;

  // answer to the frame decoder
  typedef struct packed {
    logic valid;
    logic exc; // exception answer
    logic [7:0] code; // exception code
    logic [15:0] data; // read data, coils packed lsb first
  } scccb_rsp_t;

  // action strobes to the rest of the sensor
  typedef struct packed {
    logic portCfg;
    logic apply;
    logic flush;
    logic reboot;
  } scccb_act_t;

  typedef enum logic [1:0] {
    SCC_IDLE = 2'b00,
    SCC_BUSY = 2'b01,
    SCC_DONE = 2'b11
  } scccb_state_t;
endpackage : scccb_pkg

// ===== design/scccb_coil_bank.sv
// design: coil bank, fault/status word and its mirrors
`timescale 1ns/1ps
`default_nettype none

// How it works
// - five coils; one coil per write
// - coils 8-15 reserved, no function
// - coil 0 drives line terminator switch
// - terminator restored from saved value at reset
// - coil 1 reconfigures serial port
// - coil 1 self-clears after about one second
// - coil 2 applies config or queued commands
// - coil 2 self-clears after about one second
// - coil 5 flushes FIFO, clears sequence
// - coil 5 self-clears after about one second
// - coil 7 full reboot, saved settings restored
// - reboot takes about four to five seconds
// - coil read out of range: address exception
// - write undefined coil: function exception
// - two read-only 16-bit fault words
// - word 700 via reads and diagnostic 02
// - mirrors at 200 msb, 100 lsb first
// - diagnostic sub-code 10 clears fault bits
// - port reconfigure clears serial error bits
// - unsupported baud falls back to 19200
module scccb_coil_bank
  import scccb_pkg::*;
#(
  parameter longint ACT_CYCLES = ACT_CYC_L,
  parameter longint BOOT_CYCLES = BOOT_CYC_L
) (
  input wire logic clk,
  input wire logic rstn,
  input wire scccb_req_t req,
  input wire logic savedTerm, // terminator state from nonvolatile store
  input wire logic [15:0] faultSet, // fault events from the sensor
  input wire logic [31:0] baudReq, // requested baud from comm bank
  output scccb_rsp_t rsp,
  output logic termOn,
  output scccb_act_t act,
  output logic [31:0] baudCfg,
  output logic baudWr
);

  // supported baud table
  localparam logic [31:0] BAUD_TAB [BAUD_N] = '{
    32'h0000_0960, 32'h0000_12C0, 32'h0000_2580, 32'h0000_4B00,
    32'h0000_9600, 32'h0000_E100, 32'h0001_C200, 32'h0003_8400,
    32'h0000_B6D0, 32'h0007_A120};
  localparam logic [CNT_W-1:0] ACT_N = CNT_W'(ACT_CYCLES);
  localparam logic [CNT_W-1:0] BOOT_N = CNT_W'(BOOT_CYCLES);

  // state
  logic termQ, termD; // terminator coil
  logic loadQ, loadD; // saved value not yet loaded
  scccb_state_t stQ, stD; // action sequencer
  logic [3:0] busyQ, busyD; // running coil: port, apply, flush, boot
  logic [CNT_W-1:0] cntQ, cntD; // action timer
  logic [15:0] faultQ, faultD; // sticky fault word
  scccb_rsp_t rspQ, rspD;
  scccb_act_t actQ, actD;
  logic [31:0] baudQ, baudD;
  logic baudWrQ, baudWrD;

  // coil image, lsb = coil 0
  logic [15:0] coils;
  // baud match flag and value
  logic baudOk;
  logic [31:0] baudSel;
  logic inRange; // coil read span fits the bank

  // coil image and baud tolerance check
  always_comb begin
    coils = '0; // reserved coils read zero
    coils[COIL_TERM[3:0]] = termQ;
    coils[COIL_PORT[3:0]] = busyQ[0];
    coils[COIL_APPLY[3:0]] = busyQ[1];
    coils[COIL_FLUSH[3:0]] = busyQ[2];
    coils[COIL_BOOT[3:0]] = busyQ[3];
    baudOk = 1'b0;
    baudSel = BAUD_DEFAULT;
    // first entry within tolerance wins, else 19200
    for (int i = 0; i < BAUD_N; i++) begin
      if (!baudOk && (64'(baudReq) * 100 <= 64'(BAUD_TAB[i]) *
          (100 + BAUD_TOL_PCT)) && (64'(baudReq) * 100 >=
          64'(BAUD_TAB[i]) * (100 - BAUD_TOL_PCT))) begin
        baudOk = 1'b1;
        baudSel = BAUD_TAB[i];
      end
    end
  end

  // next-state: request decode, actions, faults
  always_comb begin
    termD = termQ;
    loadD = 1'b0;
    stD = stQ;
    busyD = busyQ;
    cntD = cntQ;
    actD = '0;
    baudD = baudQ;
    baudWrD = 1'b0;
    rspD = '0;
    inRange = 1'b0;
    // fault events set, clears below lose to a set
    faultD = faultQ;
    // saved terminator on first cycle after reset
    if (loadQ) begin
      termD = savedTerm;
    end
    // action timer
    case (stQ)
      SCC_IDLE: begin
        cntD = '0;
      end
      SCC_BUSY: begin
        cntD = cntQ + 1'b1;
        if ((busyQ[3] && cntQ >= BOOT_N - 1'b1) ||
            (!busyQ[3] && cntQ >= ACT_N - 1'b1)) begin
          stD = SCC_DONE;
        end
      end
      SCC_DONE: begin
        // reboot restores saved terminator
        if (busyQ[3]) begin
          termD = savedTerm;
        end
        busyD = '0; // self-clear
        stD = SCC_IDLE;
      end
      default: stD = SCC_IDLE;
    endcase
    // requests
    if (req.valid && !busyQ[3]) begin
      rspD.valid = 1'b1;
      if (req.func == FC_READ_COILS) begin
        inRange = (req.qty != '0) &&
          (17'(req.addr) + 17'(req.qty) <= 17'(COIL_LAST) + 17'd1);
        if (!inRange) begin
          rspD.exc = 1'b1;
          rspD.code = EXC_ILL_ADDR;
        end else begin
          rspD.data = coils >> req.addr[3:0];
        end
      end else if (req.func == FC_WRITE_COIL) begin
        // single write only; a 1 starts only when idle
        if (req.addr == COIL_TERM) begin
          termD = req.qty[15];
          rspD.data = req.qty;
        end else if ((req.addr == COIL_PORT || req.addr == COIL_APPLY ||
            req.addr == COIL_FLUSH || req.addr == COIL_BOOT)) begin
          rspD.data = req.qty;
          if (req.qty[15] && stQ == SCC_IDLE) begin
            stD = SCC_BUSY;
            if (req.addr == COIL_PORT) begin
              busyD[0] = 1'b1;
              actD.portCfg = 1'b1;
              baudD = baudOk ? baudSel : BAUD_DEFAULT;
              baudWrD = 1'b1;
              faultD = faultD & ~FAULT_SERIAL_MASK;
            end else if (req.addr == COIL_APPLY) begin
              busyD[1] = 1'b1;
              actD.apply = 1'b1;
            end else if (req.addr == COIL_FLUSH) begin
              busyD[2] = 1'b1;
              actD.flush = 1'b1;
            end else begin
              busyD[3] = 1'b1;
              actD.reboot = 1'b1;
            end
          end
        end else begin
          rspD.exc = 1'b1;
          rspD.code = EXC_ILL_FUNC;
        end
      end else if (req.func == FC_WRITE_COILS) begin
        rspD.exc = 1'b1; // multi writes refused
        rspD.code = EXC_ILL_FUNC;
      end else if (req.func == FC_READ_HOLD || req.func == FC_READ_INPUT) begin
        if (req.addr == REG_FAULT || req.addr == REG_MSB_MIRROR) begin
          rspD.data = faultQ;
        end else if (req.addr == REG_LSB_MIRROR) begin
          rspD.data = {faultQ[7:0], faultQ[15:8]};
        end else if (req.addr == REG_FAULT_RSV) begin
          rspD.data = '0; // reserved word
        end else begin
          rspD.exc = 1'b1;
          rspD.code = EXC_ILL_ADDR;
        end
      end else if (req.func == FC_DIAG) begin
        if (req.addr == SFC_RET_DIAG) begin
          rspD.data = faultQ;
        end else if (req.addr == SFC_CLR_DIAG) begin
          faultD = '0;
        end else begin
          rspD.exc = 1'b1;
          rspD.code = EXC_ILL_FUNC;
        end
      end else begin
        rspD.exc = 1'b1;
        rspD.code = EXC_ILL_FUNC;
      end
    end
    // set wins over any clear this cycle
    faultD = faultD | faultSet;
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      termQ <= 1'b0;
      loadQ <= 1'b1;
      stQ <= SCC_IDLE;
      busyQ <= '0;
      cntQ <= '0;
      faultQ <= '0;
      rspQ <= '0;
      actQ <= '0;
      baudQ <= BAUD_DEFAULT;
      baudWrQ <= 1'b0;
    end else begin
      termQ <= termD;
      loadQ <= loadD;
      stQ <= stD;
      busyQ <= busyD;
      cntQ <= cntD;
      faultQ <= faultD;
      rspQ <= rspD;
      actQ <= actD;
      baudQ <= baudD;
      baudWrQ <= baudWrD;
    end
  end

  // outputs straight from flops
  assign rsp = rspQ;
  assign termOn = termQ;
  assign act = actQ;
  assign baudCfg = baudQ;
  assign baudWr = baudWrQ;

endmodule : scccb_coil_bank
`default_nettype wire

// ===== dv/scccb_coil_bank_checker.sv
// checker: port-level properties of the coil bank
`timescale 1ns/1ps
`default_nettype none
module scccb_coil_bank_checker
  import scccb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire scccb_req_t req,
  input wire logic savedTerm,
  input wire logic [15:0] faultSet,
  input wire logic [31:0] baudReq,
  input wire scccb_rsp_t rsp,
  input wire logic termOn,
  input wire scccb_act_t act,
  input wire logic [31:0] baudCfg,
  input wire logic baudWr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // single coil write of one to address a
  function automatic logic setw(scccb_req_t r, logic [15:0] a);
    return r.valid && r.func == FC_WRITE_COIL && r.addr == a && r.qty[15];
  endfunction : setw
  rsp_has_cause_a: assert property (rsp.valid |-> $past(req.valid))
    else $error("answer without request");
  one_action_a: assert property ($onehot0(act))
    else $error("two actions started together");
  port_start_a: assert property (
    act.portCfg |-> setw($past(req), COIL_PORT))
    else $error("port reconfigure without its coil write");
  apply_start_a: assert property (
    act.apply |-> setw($past(req), COIL_APPLY))
    else $error("apply without its coil write");
  flush_start_a: assert property (
    act.flush |-> setw($past(req), COIL_FLUSH))
    else $error("flush without its coil write");
  boot_start_a: assert property (
    act.reboot |-> setw($past(req), COIL_BOOT))
    else $error("reboot without its coil write");
  baud_update_a: assert property (
    $changed(baudCfg) |-> baudWr && act.portCfg)
    else $error("baud changed outside port reconfigure");
  multi_write_a: assert property (
    rsp.valid && $past(req.func == FC_WRITE_COILS)
    |-> rsp.exc && rsp.code == EXC_ILL_FUNC)
    else $error("multi coil write not refused");
  reserved_zero_a: assert property (
    rsp.valid && !rsp.exc
    && $past(req.func == FC_READ_COILS && req.addr == 16'h0008)
    |-> rsp.data == '0)
    else $error("reserved coils not zero");
  cover property (act.portCfg);
  cover property (act.reboot);
  cover property (rsp.valid && rsp.exc);
endmodule : scccb_coil_bank_checker
`default_nettype wire

// ===== dv/scccb_master_model.sv
// partner: bus master issuing one request and awaiting its answer
`timescale 1ns/1ps
`default_nettype none
module scccb_master_model
  import scccb_pkg::*;
(
  input wire logic clk,
  output scccb_req_t req,
  input wire scccb_rsp_t rsp
);
  initial req = '0; // idle from time zero
  // one request per call, so a write names one coil only
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, q,
                      output scccb_rsp_t r);
    r = '0; // stays empty while the device reboots
    @(posedge clk);
    req <= '{valid: 1'b1, func: f, addr: a, qty: q};
    @(posedge clk);
    req <= '0; // one taking edge only
    // bounded wait; the answer stands a single cycle
    repeat (3) begin
      @(posedge clk);
      if (rsp.valid === 1'b1 && r.valid !== 1'b1) r = rsp;
    end
  endtask : xfer
endmodule : scccb_master_model
`default_nettype wire

// ===== dv/tb_scccb_coil_bank.sv
// testbench: directed scenarios for the coil bank
`timescale 1ns/1ps
`default_nettype none
module tb_scccb_coil_bank
  import scccb_pkg::*;
;
  localparam longint ACT = 20; // shortened action time
  localparam longint BOOT = 50; // shortened reboot time
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic savedTerm = 1'b1;
  logic [15:0] faultSet = 16'h0000;
  logic [31:0] baudReq = 32'h0000_4B00;
  scccb_req_t req;
  scccb_rsp_t rsp;
  scccb_rsp_t r; // last answer seen
  scccb_act_t act;
  logic termOn;
  logic baudWr;
  logic [31:0] baudCfg;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  scccb_coil_bank #(.ACT_CYCLES(ACT), .BOOT_CYCLES(BOOT)) scccb_coil_bank_i (
    .clk(clk), .rstn(rstn), .req(req), .savedTerm(savedTerm),
    .faultSet(faultSet), .baudReq(baudReq), .rsp(rsp), .termOn(termOn),
    .act(act), .baudCfg(baudCfg), .baudWr(baudWr));
  scccb_master_model scccb_master_model_i (.clk(clk), .req(req), .rsp(rsp));
  initial forever #4 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic x(input logic [7:0] f, input logic [15:0] a, q);
    scccb_master_model_i.xfer(f, a, q, r);
  endtask : x
  // request that must come back as an exception with code c
  task automatic exc(input logic [7:0] f, input logic [15:0] a, q, c);
    x(f, a, q);
    chk("exception", 32'({r.valid, r.exc, r.code}), 32'({2'b11, c[7:0]}));
  endtask : exc
  task automatic t_term();
    chk("saved term", 32'(termOn), 32'h0000_0001);
    chk("baud reset", baudCfg, BAUD_DEFAULT);
    x(FC_WRITE_COIL, COIL_TERM, 16'h0000);
    chk("term off", 32'(termOn), 32'h0000_0000);
    x(FC_WRITE_COIL, COIL_TERM, 16'hFF00);
    chk("term on", 32'(termOn), 32'h0000_0001);
    x(FC_READ_COILS, COIL_TERM, 16'h0008);
    chk("coils 0-7", 32'(r.data), 32'h0000_0001);
  endtask : t_term
  task automatic t_actions();
    logic [15:0] a [3];
    a = '{COIL_PORT, COIL_APPLY, COIL_FLUSH};
    baudReq <= 32'h0000_9600;
    foreach (a[i]) begin
      x(FC_WRITE_COIL, a[i], 16'h0000);
      x(FC_READ_COILS, a[i], 16'h0001);
      chk("coil idle", 32'(r.data[0]), 32'h0000_0000);
      x(FC_WRITE_COIL, a[i], 16'hFF00);
      chk("echo", 32'(r.data), 32'h0000_FF00);
      x(FC_READ_COILS, a[i], 16'h0001);
      chk("coil busy", 32'(r.data[0]), 32'h0000_0001);
      if (i == 0) chk("baud", baudCfg, 32'h0000_9600);
      // a second action while busy is echoed but never started
      x(FC_WRITE_COIL, COIL_FLUSH, 16'hFF00);
      x(FC_READ_COILS, COIL_FLUSH, 16'h0001);
      chk("no overlap", 32'(r.data[0]), 32'(i == 2));
      repeat (ACT + 4) @(posedge clk);
      x(FC_READ_COILS, a[i], 16'h0001);
      chk("coil done", 32'(r.data[0]), 32'h0000_0000);
    end
    repeat (ACT + ACT / 2) @(posedge clk); // settle after flush
  endtask : t_actions
  task automatic t_errors();
    exc(FC_READ_COILS, 16'h0008, 16'h0009, EXC_ILL_ADDR);
    exc(FC_WRITE_COIL, 16'h0003, 16'hFF00, EXC_ILL_FUNC);
    exc(FC_WRITE_COIL, 16'h0009, 16'hFF00, EXC_ILL_FUNC);
    exc(FC_WRITE_COILS, COIL_TERM, 16'h0001, EXC_ILL_FUNC);
    exc(FC_READ_INPUT, 16'h012C, 16'h0001, EXC_ILL_ADDR);
    x(FC_READ_COILS, 16'h0008, 16'h0008);
    chk("reserved coils", 32'(r.data), 32'h0000_0000);
    x(FC_READ_HOLD, REG_FAULT_RSV, 16'h0001);
    chk("reserved word", 32'(r.data), 32'h0000_0000);
  endtask : t_errors
  task automatic t_fault();
    @(posedge clk) faultSet <= 16'h1203;
    @(posedge clk) faultSet <= 16'h0000;
    x(FC_READ_HOLD, REG_FAULT, 16'h0001);
    chk("fault word", 32'(r.data), 32'h0000_1203);
    x(FC_DIAG, SFC_RET_DIAG, 16'h0000);
    chk("diag word", 32'(r.data), 32'h0000_1203);
    x(FC_READ_INPUT, REG_MSB_MIRROR, 16'h0001);
    chk("msb mirror", 32'(r.data), 32'h0000_1203);
    x(FC_READ_HOLD, REG_LSB_MIRROR, 16'h0001);
    chk("lsb mirror", 32'(r.data), 32'h0000_0312);
    baudReq <= 32'h0000_3039; // far from every supported rate
    x(FC_WRITE_COIL, COIL_PORT, 16'hFF00);
    chk("baud fallback", baudCfg, BAUD_DEFAULT);
    x(FC_READ_HOLD, REG_FAULT, 16'h0001);
    chk("serial bits", 32'(r.data), 32'h0000_1200);
    repeat (ACT + 4) @(posedge clk);
    x(FC_DIAG, SFC_CLR_DIAG, 16'h0000);
    x(FC_READ_HOLD, REG_FAULT, 16'h0001);
    chk("cleared", 32'(r.data), 32'h0000_0000);
  endtask : t_fault
  task automatic t_boot();
    savedTerm <= 1'b0; // differs from the live setting
    x(FC_WRITE_COIL, COIL_BOOT, 16'hFF00);
    x(FC_READ_COILS, COIL_BOOT, 16'h0001);
    chk("ignored", 32'(r.valid), 32'h0000_0000);
    repeat (BOOT + 4) @(posedge clk);
    chk("term restored", 32'(termOn), 32'h0000_0000);
    x(FC_READ_COILS, COIL_BOOT, 16'h0001);
    chk("boot done", 32'({r.valid, r.data[0]}), 32'h0000_0002);
    savedTerm <= 1'b1;
    rstn <= 1'b0; // second reset in mid-run
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk("term after reset", 32'(termOn), 32'h0000_0001);
    chk("baud after reset", baudCfg, BAUD_DEFAULT);
  endtask : t_boot
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_term();
    t_actions();
    t_errors();
    t_fault();
    t_boot();
    final_report();
  end
endmodule : tb_scccb_coil_bank
bind scccb_coil_bank scccb_coil_bank_checker scccb_coil_bank_checker_i (
  .clk(clk), .rstn(rstn), .req(req), .savedTerm(savedTerm),
  .faultSet(faultSet), .baudReq(baudReq), .rsp(rsp), .termOn(termOn),
  .act(act), .baudCfg(baudCfg), .baudWr(baudWr));
`default_nettype wire
